// >>> hw/modulo_pkg.sv
// package: register map, field layout and carriers for the circular address generator
package modulo_pkg;

  // register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // register offsets (word index on the plain register port)
  localparam logic [3:0] OFF_CONTROL = 4'h0;
  localparam logic [3:0] OFF_X_START = 4'h1;
  localparam logic [3:0] OFF_X_END = 4'h2;
  localparam logic [3:0] OFF_Y_START = 4'h3;
  localparam logic [3:0] OFF_Y_END = 4'h4;
  localparam logic [3:0] OFF_STATUS = 4'h5;
  localparam logic [3:0] OFF_X_LENGTH = 4'h6;
  localparam logic [3:0] OFF_Y_LENGTH = 4'h7;

  // control field positions
  localparam int X_SEL_LSB = 0;
  localparam int Y_SEL_LSB = 4;
  localparam int Y_EN_BIT = 14;
  localparam int X_EN_BIT = 15;
  localparam logic [3:0] SEL_OFF = 4'hf;
  localparam logic [15:0] CONTROL_MASK = 16'hc0ff;

  // status field positions
  localparam int ST_X_ACTIVE = 0;
  localparam int ST_Y_ACTIVE = 1;
  localparam int ST_X_WRAP = 2;
  localparam int ST_Y_WRAP = 3;

  // values after reset
  localparam logic [15:0] RST_CONTROL = 16'h0000;
  localparam logic [15:0] RST_BOUND = 16'h0000;

  // address generator channels
  localparam int NUM_CH = 3;
  localparam int CH_XRD = 0;
  localparam int CH_XWR = 1;
  localparam int CH_Y = 2;

  // pointer update request from an address generator
  typedef struct packed {
    logic valid;
    logic prog;
    logic [3:0] wreg;
    logic [15:0] ptr;
    logic [15:0] step;
  } ptr_req_t;

  // updated pointer returned to the address generator
  typedef struct packed {
    logic valid;
    logic prog;
    logic circular;
    logic wrapped;
    logic [15:0] ptr;
  } ptr_rsp_t;

endpackage

// >>> hw/modulo_circular_address_gen.sv
// modulo (circular buffer) pointer update logic for the X and Y address generators
// Notes on behaviour
// - one circular buffer in X and one in Y at once; X also covers program space
// - wrap-around applies alike to data space and program space pointer updates
// - any working pointer but number 15 (the off code) may be selected; frame and stack pointers are discouraged
// - power-of-two buffers may go both ways; each update checks only the bound in its step direction
// - start and end address of each space sit in their own 16-bit registers
// - buffer length comes only from end minus start, no length setting
// - buffers up to 32K words, 64 Kbytes, are supported
// - X select of 15 turns off wrapping for X read and X write generators
// - Y select of 15 turns off wrapping for the Y generator
// - X select in control bits 3..0; X active when not 15 and bit 15 set
// - Y select in control bits 7..4; Y active when not 15 and bit 14 set
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module modulo_circular_address_gen
  import modulo_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // pointer update requests: x read, x write, y
  input wire ptr_req_t [NUM_CH-1:0] upd_req,
  // updated pointers, one cycle after the request
  output ptr_rsp_t [NUM_CH-1:0] upd_rsp,
  // space enables as seen by the core
  output logic x_circular_active,
  output logic y_circular_active
);

  typedef struct packed {
    logic [15:0] modulo_control;
    logic [15:0] x_buffer_start;
    logic [15:0] x_buffer_end;
    logic [15:0] y_buffer_start;
    logic [15:0] y_buffer_end;
    logic x_wrapped;
    logic y_wrapped;
    logic x_active;
    logic y_active;
    logic [15:0] rdata;
    ptr_rsp_t [NUM_CH-1:0] rsp;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  // space is active when its enable is set and its select is not the off code
  function automatic logic space_active(input logic en, input logic [3:0] sel);
    space_active = en & (sel != SEL_OFF);
  endfunction

  // one pointer update with boundary checks
  function automatic ptr_rsp_t step_pointer(
    input ptr_req_t q,
    input logic act,
    input logic [3:0] sel,
    input logic [15:0] lo,
    input logic [15:0] hi,
    input logic word_only
  );
    logic hit;
    logic up;
    logic [16:0] sum;
    logic [15:0] mag;
    logic [15:0] nxt;
    ptr_rsp_t r;
    hit = act & (q.wreg == sel);
    up = ~q.step[15];
    sum = {1'b0, q.ptr} + {1'b0, q.step};
    mag = 16'h0000 - q.step;
    nxt = sum[15:0];
    r = '0;
    r.valid = q.valid;
    r.prog = q.prog;
    r.circular = hit;
    r.ptr = nxt;
    if (hit) begin
      if (up) begin
        // upper bound, including a carry out of the 16-bit space
        if (sum[16] | (nxt > hi)) begin
          r.ptr = lo;
          r.wrapped = 1'b1;
        end
      end else begin
        // lower bound, including a borrow below address zero
        if ((q.ptr < mag) | (nxt < lo)) begin
          r.ptr = hi;
          r.wrapped = 1'b1;
        end
      end
    end
    // y space works on words only: the byte bit stays clear
    if (word_only) begin
      r.ptr[0] = 1'b0;
    end
    step_pointer = r;
  endfunction

  logic x_act;
  logic y_act;
  logic [3:0] x_sel;
  logic [3:0] y_sel;
  logic [15:0] x_len;
  logic [15:0] y_len;
  logic x_wrap_evt;
  logic y_wrap_evt;

  assign x_sel = state_r.modulo_control[X_SEL_LSB +: 4];
  assign y_sel = state_r.modulo_control[Y_SEL_LSB +: 4];
  assign x_act = space_active(state_r.modulo_control[X_EN_BIT], x_sel);
  assign y_act = space_active(state_r.modulo_control[Y_EN_BIT], y_sel);
  assign x_len = state_r.x_buffer_end - state_r.x_buffer_start;
  assign y_len = state_r.y_buffer_end - state_r.y_buffer_start;

  always_comb begin
    state_nxt = state_r;
    x_wrap_evt = 1'b0;
    y_wrap_evt = 1'b0;

    // both X generators share the X buffer, Y has its own
    state_nxt.rsp[CH_XRD] = step_pointer(upd_req[CH_XRD], x_act, x_sel,
      state_r.x_buffer_start, state_r.x_buffer_end, 1'b0);
    state_nxt.rsp[CH_XWR] = step_pointer(upd_req[CH_XWR], x_act, x_sel,
      state_r.x_buffer_start, state_r.x_buffer_end, 1'b0);
    state_nxt.rsp[CH_Y] = step_pointer(upd_req[CH_Y], y_act, y_sel,
      state_r.y_buffer_start, state_r.y_buffer_end, 1'b1);

    for (int i = 0; i < NUM_CH; i++) begin
      if (!upd_req[i].valid) begin
        state_nxt.rsp[i] = '0;
      end
    end
    x_wrap_evt = state_nxt.rsp[CH_XRD].wrapped | state_nxt.rsp[CH_XWR].wrapped;
    y_wrap_evt = state_nxt.rsp[CH_Y].wrapped;

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        OFF_CONTROL: begin
          state_nxt.modulo_control = reg_wdata & CONTROL_MASK;
        end
        OFF_X_START: begin
          state_nxt.x_buffer_start = reg_wdata;
        end
        OFF_X_END: begin
          state_nxt.x_buffer_end = reg_wdata;
        end
        OFF_Y_START: begin
          state_nxt.y_buffer_start = reg_wdata;
        end
        OFF_Y_END: begin
          state_nxt.y_buffer_end = reg_wdata;
        end
        OFF_STATUS: begin
          // write one to clear the wrap flags
          if (reg_wdata[ST_X_WRAP]) begin
            state_nxt.x_wrapped = 1'b0;
          end
          if (reg_wdata[ST_Y_WRAP]) begin
            state_nxt.y_wrapped = 1'b0;
          end
        end
        default: begin
          state_nxt.modulo_control = state_r.modulo_control;
        end
      endcase
    end

    // space enables follow the control value that takes effect at this edge
    state_nxt.x_active = space_active(state_nxt.modulo_control[X_EN_BIT],
      state_nxt.modulo_control[X_SEL_LSB +: 4]);
    state_nxt.y_active = space_active(state_nxt.modulo_control[Y_EN_BIT],
      state_nxt.modulo_control[Y_SEL_LSB +: 4]);

    // a wrap in the clearing cycle keeps its flag
    if (x_wrap_evt) begin
      state_nxt.x_wrapped = 1'b1;
    end
    if (y_wrap_evt) begin
      state_nxt.y_wrapped = 1'b1;
    end

    // read data for the next cycle only
    state_nxt.rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        OFF_CONTROL: begin
          state_nxt.rdata = state_r.modulo_control;
        end
        OFF_X_START: begin
          state_nxt.rdata = state_r.x_buffer_start;
        end
        OFF_X_END: begin
          state_nxt.rdata = state_r.x_buffer_end;
        end
        OFF_Y_START: begin
          state_nxt.rdata = state_r.y_buffer_start;
        end
        OFF_Y_END: begin
          state_nxt.rdata = state_r.y_buffer_end;
        end
        OFF_STATUS: begin
          state_nxt.rdata[ST_X_ACTIVE] = x_act;
          state_nxt.rdata[ST_Y_ACTIVE] = y_act;
          state_nxt.rdata[ST_X_WRAP] = state_r.x_wrapped;
          state_nxt.rdata[ST_Y_WRAP] = state_r.y_wrapped;
        end
        OFF_X_LENGTH: begin
          state_nxt.rdata = x_len;
        end
        OFF_Y_LENGTH: begin
          state_nxt.rdata = y_len;
        end
        default: begin
          state_nxt.rdata = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_r <= '0;
      state_r.modulo_control <= RST_CONTROL;
      state_r.x_buffer_start <= RST_BOUND;
      state_r.x_buffer_end <= RST_BOUND;
      state_r.y_buffer_start <= RST_BOUND;
      state_r.y_buffer_end <= RST_BOUND;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign reg_rdata = state_r.rdata;
  assign upd_rsp = state_r.rsp;
  assign x_circular_active = state_r.x_active;
  assign y_circular_active = state_r.y_active;

endmodule

`default_nettype wire

// >>> bench/modulo_monitor.sv
// checker: port assertions for the circular address generator
`timescale 1ns/1ps
`default_nettype none
module modulo_monitor
  import modulo_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  // pointer port
  input wire ptr_req_t [NUM_CH-1:0] upd_req,
  input wire ptr_rsp_t [NUM_CH-1:0] upd_rsp,
  // space enables
  input wire logic x_circular_active,
  input wire logic y_circular_active
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  x_enable_set_a: assert property (reg_wr && reg_addr == OFF_CONTROL |=> x_circular_active ==
    ($past(reg_wdata[15]) && $past(reg_wdata[3:0]) != SEL_OFF)) else $error("x enable wrong");
  y_enable_set_a: assert property (reg_wr && reg_addr == OFF_CONTROL |=> y_circular_active ==
    ($past(reg_wdata[14]) && $past(reg_wdata[7:4]) != SEL_OFF)) else $error("y enable wrong");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not idle");
  x_linear_a: assert property (upd_req[0].valid && !x_circular_active |=> !upd_rsp[0].circular
    && upd_rsp[0].ptr == $past(upd_req[0].ptr) + $past(upd_req[0].step)) else $error("x linear");
  y_linear_a: assert property (upd_req[2].valid && !y_circular_active |=> !upd_rsp[2].circular
    && upd_rsp[2].ptr == (($past(upd_req[2].ptr) + $past(upd_req[2].step)) & 16'hfffe))
    else $error("y linear");
  rsp_idle_a: assert property (!upd_req[1].valid |=> upd_rsp[1] == '0) else $error("rsp idle");
  rsp_prog_a: assert property (upd_req[1].valid |=> upd_rsp[1].valid &&
    upd_rsp[1].prog == $past(upd_req[1].prog)) else $error("rsp valid or prog");
  wrap_circ_a: assert property (upd_rsp[0].wrapped |-> upd_rsp[0].circular)
    else $error("wrap without match");
  x_write_off_a: assert property (!x_circular_active |=> !upd_rsp[1].circular)
    else $error("x write wraps while off");
endmodule
bind modulo_circular_address_gen modulo_monitor mon (.sys_clk(sys_clk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .upd_req(upd_req), .upd_rsp(upd_rsp),
  .x_circular_active(x_circular_active), .y_circular_active(y_circular_active));
`default_nettype wire

// >>> bench/core_agen_model.sv
// partner: core address generator with its working pointer registers
`timescale 1ns/1ps
`default_nettype none
module core_agen_model
  import modulo_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // bench commands
  input wire logic go,
  input wire logic ld,
  input wire logic [1:0] ch,
  input wire logic [3:0] wreg,
  input wire logic prog,
  input wire logic [15:0] step,
  // pointer port
  output ptr_req_t [NUM_CH-1:0] upd_req,
  input wire ptr_rsp_t [NUM_CH-1:0] upd_rsp
);
  logic [15:0] wfile [16];
  logic [3:0] pend;
  initial upd_req = '0;
  always @(posedge sys_clk) begin
    upd_req <= '0;
    if (ld) wfile[wreg] <= step;
    if (go) begin
      upd_req[ch] <= {1'b1, prog, wreg, wfile[wreg], step};
      pend <= wreg;
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (upd_rsp[i].valid) wfile[pend] <= upd_rsp[i].ptr;
    end
  end
endmodule
`default_nettype wire

// >>> bench/tb_modulo_circular_address_gen.sv
// testbench: register and pointer update sequences for the circular address generator
`timescale 1ns/1ps
`default_nettype none
module tb_modulo_circular_address_gen
  import modulo_pkg::*;
;
  logic sys_clk, reset_n, reg_wr, reg_rd, go, ld, prog, x_act, y_act;
  logic [3:0] reg_addr, wreg;
  logic [15:0] reg_wdata, reg_rdata, step;
  logic [1:0] ch;
  ptr_req_t [NUM_CH-1:0] upd_req;
  ptr_rsp_t [NUM_CH-1:0] upd_rsp;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  modulo_circular_address_gen dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .upd_req(upd_req), .upd_rsp(upd_rsp), .x_circular_active(x_act), .y_circular_active(y_act));
  core_agen_model core (.sys_clk(sys_clk), .go(go), .ld(ld), .ch(ch), .wreg(wreg), .prog(prog),
    .step(step), .upd_req(upd_req), .upd_rsp(upd_rsp));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task chk(input string n, input logic [17:0] e, input logic [17:0] s);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk("rdata", {2'b00, e}, {2'b00, reg_rdata});
  endtask
  task put(input logic [3:0] r, input logic [15:0] v);
    @(posedge sys_clk);
    ld <= 1'b1;
    wreg <= r;
    step <= v;
    @(posedge sys_clk);
    ld <= 1'b0;
  endtask
  task upd(input logic [1:0] c, input logic [3:0] r, input logic p, input logic [15:0] s,
           input logic [17:0] e);
    @(posedge sys_clk);
    go <= 1'b1;
    ch <= c;
    wreg <= r;
    prog <= p;
    step <= s;
    @(posedge sys_clk);
    go <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("rsp", e, {upd_rsp[c].circular, upd_rsp[c].wrapped, upd_rsp[c].ptr});
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      finish_test();
    end
  end
  initial begin
    {reset_n, reg_wr, reg_rd, go, ld, prog, reg_addr, wreg, reg_wdata, step, ch} = '0;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (int a = 0; a < 9; a++) rd(a[3:0], 16'h0000);
    wr(OFF_X_START, 16'h0100);
    wr(OFF_X_END, 16'h011e);
    wr(OFF_Y_START, 16'h0200);
    wr(OFF_Y_END, 16'h021e);
    rd(OFF_X_END, 16'h011e);
    rd(OFF_Y_LENGTH, 16'h001e);
    wr(OFF_CONTROL, 16'hffff);
    rd(OFF_CONTROL, 16'hc0ff);
    rd(OFF_STATUS, 16'h0000);
    wr(OFF_CONTROL, 16'hc032);
    rd(OFF_STATUS, 16'h0003);
    put(4'h2, 16'h011c);
    upd(CH_XRD, 4'h2, 1'b0, 16'h0002, 18'h2011e);
    upd(CH_XRD, 4'h2, 1'b0, 16'h0002, 18'h30100);
    upd(CH_XWR, 4'h2, 1'b0, 16'hfffe, 18'h3011e);
    upd(CH_XWR, 4'h2, 1'b1, 16'h0002, 18'h30100);
    put(4'h1, 16'h011e);
    upd(CH_XRD, 4'h1, 1'b0, 16'h0002, 18'h00120);
    put(4'h3, 16'h021e);
    upd(CH_Y, 4'h3, 1'b0, 16'h0002, 18'h30200);
    upd(CH_Y, 4'h3, 1'b0, 16'hfffe, 18'h3021e);
    rd(OFF_STATUS, 16'h000f);
    wr(OFF_STATUS, 16'h000c);
    rd(OFF_STATUS, 16'h0003);
    wr(OFF_CONTROL, 16'hc0f2);
    upd(CH_Y, 4'h3, 1'b0, 16'h0002, 18'h00220);
    wr(OFF_CONTROL, 16'hc03f);
    put(4'h2, 16'h011e);
    upd(CH_XRD, 4'h2, 1'b0, 16'h0002, 18'h00120);
    upd(CH_XWR, 4'h2, 1'b0, 16'hfffe, 18'h0011e);
    wr(OFF_CONTROL, 16'h8032);
    rd(OFF_STATUS, 16'h0001);
    wr(OFF_X_START, 16'h0000);
    wr(OFF_X_END, 16'hfffe);
    wr(OFF_CONTROL, 16'h8002);
    rd(OFF_X_LENGTH, 16'hfffe);
    put(4'h2, 16'hfffe);
    upd(CH_XRD, 4'h2, 1'b0, 16'h0002, 18'h30000);
    finish_test();
  end
endmodule
`default_nettype wire
